// file: hw/tmpwm_pkg.sv
// Package: register map, fields and carrier types of the PWM timer block
package tmpwm_pkg;
    localparam int          DW = 8;
    localparam logic [11:0] OFF_CTRL    = 12'h000;
    localparam logic [11:0] OFF_CYCLE   = 12'h004;
    localparam logic [11:0] OFF_DUTY    = 12'h008;
    localparam logic [11:0] OFF_P1DIR   = 12'h00C;
    localparam logic [11:0] OFF_P1LAT   = 12'h010;
    localparam logic [11:0] OFF_STATUS  = 12'h014;
    localparam logic [11:0] OFF_MASK    = 12'h018;
    localparam logic [11:0] OFF_COUNT   = 12'h01C;
    localparam logic [11:0] OFF_P1BIT   = 12'h020;
    localparam int          CTRL_EN     = 0;
    localparam int          CTRL_ACTLVL = 1;
    localparam int          CTRL_DIVW   = 4;
    localparam int          CTRL_DIVLSB = 2;
    localparam int          BIT_VAL     = 3;
    localparam int          PWM_PIN_A   = 5;
    localparam int          PWM_PIN_B   = 6;
    localparam logic [7:0]  P1DIR_RST   = 8'hFF;
    localparam logic [7:0]  P1LAT_RST   = 8'h00;
    localparam logic [7:0]  CYCLE_RST   = 8'hFF;
    localparam logic [7:0]  DUTY_RST    = 8'h00;
    localparam logic [7:0]  CNT_ZERO    = 8'h00;
    localparam logic [7:0]  CNT_ONE     = 8'h01;
    localparam logic [31:0] WORD_ZERO   = 32'h0000_0000;
    localparam logic [1:0]  HTRANS_NSEQ = 2'h2;
    localparam logic [1:0]  HTRANS_SEQ  = 2'h3;
    localparam logic        HRESP_OKAY  = 1'b0;

    // Control register fields
    typedef struct packed {
        logic [3:0] prescale;
        logic       active_high;
        logic       run;
    } tmpwm_ctrl_s;

    // Port-1 pin carrier: value, output enable (low = driving)
    typedef struct packed {
        logic [7:0] value;
        logic [7:0] oe_n;
    } tmpwm_port_s;

    typedef enum logic {TMPWM_CMP_CYCLE, TMPWM_CMP_DUTY} tmpwm_cmp_e;
endpackage

// file: hw/tmpwm_prescaler.sv
// Module: count-clock prescaler producing one-cycle tick pulses
`timescale 1ns/1ps
module tmpwm_prescaler (
    input  wire logic       SYS_CLK_I,  // System clock
    input  wire logic       RST_I,      // Sync reset, active high
    input  wire logic       run_i,      // Counting enabled
    input  wire logic [3:0] sel_i,      // Divide by 2**sel
    output logic            tick_o      // Count clock pulse
);
    logic [15:0] div_ff;
    logic [15:0] nxt_div;
    logic [15:0] limit;

    assign limit   = 16'((32'h1 << sel_i) - 32'h1);
    assign nxt_div = (!run_i || div_ff == limit) ? 16'h0000 : div_ff + 16'h0001;
    // Tick on the last step; restarting aligns the first count to enable
    assign tick_o  = run_i && (div_ff == limit);

    always_ff @(posedge SYS_CLK_I) begin
        if (RST_I) begin
            div_ff <= 16'h0000;
        end else begin
            div_ff <= nxt_div;
        end
    end
endmodule

// file: hw/tmpwm_top.sv
// Module: 8-bit PWM timer with port-1 direction register, AHB-Lite slave
// Overview of operation
// - Duty compare writes accepted while running; new value used next compare.
// - Counter starts counting only once the run enable bit is one.
// - After enabling, the first compare is against the cycle compare value.
// - Cycle match clears counter, raises interrupt request, drives output active.
// - Cycle match switches the compare target to the duty compare register.
// - Duty match drives output inactive and switches target back to cycle.
// - Duty match neither clears counter nor raises interrupt request.
// - Direction bit zero enables output buffer; one makes pin an input.
// - Port-1 direction register resets to all ones, pins start as inputs.
// - Port-1 direction register takes single-bit and whole-byte writes.
`timescale 1ns/1ps
module tmpwm_top (
    input  wire logic        SYS_CLK_I,    // System clock, 100 MHz
    input  wire logic        RST_I,        // Sync reset, active high
    input  wire logic        HSEL_I,       // AHB slave select
    input  wire logic [31:0] HADDR_I,      // AHB address
    input  wire logic [1:0]  HTRANS_I,     // AHB transfer type
    input  wire logic        HWRITE_I,     // AHB write
    input  wire logic [2:0]  HSIZE_I,      // AHB size
    input  wire logic        HREADY_I,     // AHB bus ready
    input  wire logic [31:0] HWDATA_I,     // AHB write data
    output logic      [31:0] HRDATA_O,     // AHB read data
    output logic             HREADYOUT_O,  // AHB slave ready
    output logic             HRESP_O,      // AHB response
    input  wire logic [7:0]  P1_PIN_I,     // Port-1 pin levels
    output logic      [7:0]  P1_PIN_O,     // Port-1 pin drive values
    output logic      [7:0]  P1_OE_N_O,    // Port-1 drive enable, low drives
    output logic             PWM_OUT_O,    // Timer PWM output level
    output logic             IRQ_O         // Level interrupt
);
    // Address-phase capture
    logic        wr_pend_ff;
    logic [11:0] addr_ff;
    logic        nxt_wr_pend;
    logic        addr_take;

    // Registers
    tmpwm_pkg::tmpwm_ctrl_s ctrl_ff;
    logic [7:0]  cycle_ff;
    logic [7:0]  duty_ff;
    logic [7:0]  p1dir_ff;
    logic [7:0]  p1lat_ff;
    logic        stat_ff;
    logic        mask_ff;
    logic [31:0] rdata_ff;

    // Timer state
    logic [7:0]  count_ff;
    logic        level_ff;
    tmpwm_pkg::tmpwm_cmp_e tgt_ff;
    logic        run_d_ff;

    logic        tick;
    logic        run;
    logic [7:0]  cmp_val;
    logic        match;
    logic        cyc_match;
    logic        duty_match;
    logic [7:0]  nxt_count;
    logic        nxt_level;
    tmpwm_pkg::tmpwm_cmp_e nxt_tgt;
    logic        irq_evt;

    logic        we_ctrl;
    logic        we_cycle;
    logic        we_duty;
    logic        we_p1dir;
    logic        we_p1lat;
    logic        we_stat;
    logic        we_mask;
    logic        we_p1bit;
    logic [7:0]  bit_mask;
    logic [7:0]  nxt_p1dir;
    logic        nxt_stat;
    logic [31:0] nxt_rdata;
    logic        hit;
    tmpwm_pkg::tmpwm_port_s port;

    function automatic logic sel_is(input logic [11:0] a,
                                    input logic [11:0] off);
        sel_is = (a == off);
    endfunction

    // Zero-wait slave: reads are sampled at the address phase
    assign addr_take   = HSEL_I && HREADY_I &&
                         (HTRANS_I == tmpwm_pkg::HTRANS_NSEQ ||
                          HTRANS_I == tmpwm_pkg::HTRANS_SEQ);
    assign nxt_wr_pend = addr_take && HWRITE_I;
    assign HREADYOUT_O = 1'b1;
    assign HRESP_O     = tmpwm_pkg::HRESP_OKAY;
    assign HRDATA_O    = rdata_ff;

    assign we_ctrl  = wr_pend_ff && sel_is(addr_ff, tmpwm_pkg::OFF_CTRL);
    assign we_cycle = wr_pend_ff && sel_is(addr_ff, tmpwm_pkg::OFF_CYCLE);
    assign we_duty  = wr_pend_ff && sel_is(addr_ff, tmpwm_pkg::OFF_DUTY);
    assign we_p1dir = wr_pend_ff && sel_is(addr_ff, tmpwm_pkg::OFF_P1DIR);
    assign we_p1lat = wr_pend_ff && sel_is(addr_ff, tmpwm_pkg::OFF_P1LAT);
    assign we_stat  = wr_pend_ff && sel_is(addr_ff, tmpwm_pkg::OFF_STATUS);
    assign we_mask  = wr_pend_ff && sel_is(addr_ff, tmpwm_pkg::OFF_MASK);
    assign we_p1bit = wr_pend_ff && sel_is(addr_ff, tmpwm_pkg::OFF_P1BIT);

    // Single-bit write: data[2:0] picks the bit, data[3] is its value
    assign bit_mask  = 8'(8'h01 << HWDATA_I[2:0]);
    assign nxt_p1dir = we_p1dir ? HWDATA_I[7:0] :
                       we_p1bit ? (HWDATA_I[tmpwm_pkg::BIT_VAL] ?
                                   (p1dir_ff | bit_mask) :
                                   (p1dir_ff & ~bit_mask)) :
                       p1dir_ff;

    // Timer core
    assign run        = ctrl_ff.run;
    assign cmp_val    = (tgt_ff == tmpwm_pkg::TMPWM_CMP_CYCLE) ?
                        cycle_ff : duty_ff;
    assign match      = tick && (count_ff == cmp_val);
    assign cyc_match  = match && (tgt_ff == tmpwm_pkg::TMPWM_CMP_CYCLE);
    assign duty_match = match && (tgt_ff == tmpwm_pkg::TMPWM_CMP_DUTY);
    assign irq_evt    = cyc_match;

    always_comb begin
        nxt_count = count_ff;
        nxt_level = level_ff;
        nxt_tgt   = tgt_ff;
        if (!run || !run_d_ff) begin
            // Idle or just enabled: zero, inactive, cycle first
            nxt_count = tmpwm_pkg::CNT_ZERO;
            nxt_level = 1'b0;
            nxt_tgt   = tmpwm_pkg::TMPWM_CMP_CYCLE;
        end else if (cyc_match) begin
            nxt_count = tmpwm_pkg::CNT_ZERO;
            nxt_level = 1'b1;
            nxt_tgt   = tmpwm_pkg::TMPWM_CMP_DUTY;
        end else if (duty_match) begin
            nxt_count = count_ff + tmpwm_pkg::CNT_ONE;
            nxt_level = 1'b0;
            nxt_tgt   = tmpwm_pkg::TMPWM_CMP_CYCLE;
        end else if (tick) begin
            nxt_count = count_ff + tmpwm_pkg::CNT_ONE;
        end
    end

    // Set wins over a write-one clear in the same cycle
    assign nxt_stat = irq_evt | (stat_ff & ~(we_stat & HWDATA_I[0]));
    assign IRQ_O    = stat_ff & mask_ff;

    // Timer pin override on bits 5 and 6 when latch and direction are zero
    always_comb begin
        port.value = p1lat_ff;
        port.value[tmpwm_pkg::PWM_PIN_A] = p1lat_ff[tmpwm_pkg::PWM_PIN_A] |
                                           PWM_OUT_O;
        port.value[tmpwm_pkg::PWM_PIN_B] = p1lat_ff[tmpwm_pkg::PWM_PIN_B] |
                                           PWM_OUT_O;
        port.oe_n  = p1dir_ff;
    end
    assign P1_PIN_O  = port.value;
    assign P1_OE_N_O = port.oe_n;
    assign PWM_OUT_O = ctrl_ff.active_high ? level_ff : ~level_ff;

    assign hit = addr_take && (HADDR_I[11:0] <= tmpwm_pkg::OFF_P1BIT) &&
                 (HADDR_I[1:0] == 2'h0) && (HADDR_I[31:12] == 20'h00000);
    always_comb begin
        nxt_rdata = tmpwm_pkg::WORD_ZERO;
        if (hit) begin
            unique case (HADDR_I[11:0])
                tmpwm_pkg::OFF_CTRL:   nxt_rdata = 32'(ctrl_ff);
                tmpwm_pkg::OFF_CYCLE:  nxt_rdata = 32'(cycle_ff);
                tmpwm_pkg::OFF_DUTY:   nxt_rdata = 32'(duty_ff);
                tmpwm_pkg::OFF_P1DIR:  nxt_rdata = 32'(p1dir_ff);
                tmpwm_pkg::OFF_P1LAT:  nxt_rdata = 32'(p1lat_ff);
                tmpwm_pkg::OFF_STATUS: nxt_rdata = 32'(stat_ff);
                tmpwm_pkg::OFF_MASK:   nxt_rdata = 32'(mask_ff);
                tmpwm_pkg::OFF_COUNT:  nxt_rdata = 32'(count_ff);
                tmpwm_pkg::OFF_P1BIT:  nxt_rdata = 32'(P1_PIN_I);
                default:               nxt_rdata = tmpwm_pkg::WORD_ZERO;
            endcase
        end
    end

    tmpwm_prescaler u_presc (
        .SYS_CLK_I (SYS_CLK_I),
        .RST_I     (RST_I),
        .run_i     (run && run_d_ff),
        .sel_i     (ctrl_ff.prescale),
        .tick_o    (tick)
    );

    // Bus capture: write intent and address wait for the data phase
    always_ff @(posedge SYS_CLK_I) begin
        if (RST_I) begin
            wr_pend_ff <= 1'b0;
        end else begin
            wr_pend_ff <= nxt_wr_pend && (HADDR_I[31:12] == 20'h00000);
        end
    end

    always_ff @(posedge SYS_CLK_I) begin
        if (RST_I) begin
            addr_ff <= 12'h000;
        end else begin
            addr_ff <= HADDR_I[11:0];
        end
    end

    // Read word fixed at the address phase, shown in the data phase
    always_ff @(posedge SYS_CLK_I) begin
        if (RST_I) begin
            rdata_ff <= tmpwm_pkg::WORD_ZERO;
        end else begin
            rdata_ff <= nxt_rdata;
        end
    end

    always_ff @(posedge SYS_CLK_I) begin
        if (RST_I) begin
            ctrl_ff <= '0;
        end else if (we_ctrl) begin
            ctrl_ff <= HWDATA_I[5:0];
        end
    end

    // Cycle value is only safe to change while stopped
    always_ff @(posedge SYS_CLK_I) begin
        if (RST_I) begin
            cycle_ff <= tmpwm_pkg::CYCLE_RST;
        end else if (we_cycle) begin
            cycle_ff <= HWDATA_I[7:0];
        end
    end

    always_ff @(posedge SYS_CLK_I) begin
        if (RST_I) begin
            duty_ff <= tmpwm_pkg::DUTY_RST;
        end else if (we_duty) begin
            duty_ff <= HWDATA_I[7:0];
        end
    end

    always_ff @(posedge SYS_CLK_I) begin
        if (RST_I) begin
            p1dir_ff <= tmpwm_pkg::P1DIR_RST;
        end else begin
            p1dir_ff <= nxt_p1dir;
        end
    end

    always_ff @(posedge SYS_CLK_I) begin
        if (RST_I) begin
            p1lat_ff <= tmpwm_pkg::P1LAT_RST;
        end else if (we_p1lat) begin
            p1lat_ff <= HWDATA_I[7:0];
        end
    end

    always_ff @(posedge SYS_CLK_I) begin
        if (RST_I) begin
            stat_ff <= 1'b0;
        end else begin
            stat_ff <= nxt_stat;
        end
    end

    always_ff @(posedge SYS_CLK_I) begin
        if (RST_I) begin
            mask_ff <= 1'b0;
        end else if (we_mask) begin
            mask_ff <= HWDATA_I[0];
        end
    end

    always_ff @(posedge SYS_CLK_I) begin
        if (RST_I) begin
            count_ff <= tmpwm_pkg::CNT_ZERO;
        end else begin
            count_ff <= nxt_count;
        end
    end

    always_ff @(posedge SYS_CLK_I) begin
        if (RST_I) begin
            level_ff <= 1'b0;
        end else begin
            level_ff <= nxt_level;
        end
    end

    always_ff @(posedge SYS_CLK_I) begin
        if (RST_I) begin
            tgt_ff <= tmpwm_pkg::TMPWM_CMP_CYCLE;
        end else begin
            tgt_ff <= nxt_tgt;
        end
    end

    // One-cycle enable delay restarts prescaler and counter together
    always_ff @(posedge SYS_CLK_I) begin
        if (RST_I) begin
            run_d_ff <= 1'b0;
        end else begin
            run_d_ff <= run;
        end
    end
endmodule

// file: verification/tmpwm_asserts.sv
// Checker: bus, pin and interrupt relations at the timer ports
`timescale 1ns/1ps
module tmpwm_asserts (
    input  wire logic       SYS_CLK_I,   // Clock
    input  wire logic       RST_I,       // Reset
    input  wire logic       HSEL_I,      // Select
    input  wire logic [1:0] HTRANS_I,    // Transfer type
    input  wire logic       HWRITE_I,    // Write
    input  wire logic       HREADY_I,    // Bus ready
    input  wire logic       HREADYOUT_O, // Slave ready
    input  wire logic       HRESP_O,     // Response
    input  wire logic [7:0] P1_PIN_O,    // Pin drive
    input  wire logic [7:0] P1_OE_N_O,   // Drive enable
    input  wire logic       PWM_OUT_O,   // Timer output
    input  wire logic       IRQ_O        // Interrupt
);
    logic wr_ph_ff;
    logic nxt_wr_ph;
    // High in a write data phase: only then may direction change or IRQ_O fall
    assign nxt_wr_ph = HSEL_I & HTRANS_I[1] & HWRITE_I & HREADY_I;
    always_ff @(posedge SYS_CLK_I) wr_ph_ff <= nxt_wr_ph;
    default clocking cb @(posedge SYS_CLK_I); endclocking
    default disable iff (RST_I);
    chk_bus_ready: assert property (HREADYOUT_O && HRESP_O == 1'b0)
        else $error("slave not ready or not okay");
    chk_dir_reset: assert property (
        $past(RST_I) |-> P1_OE_N_O == 8'hFF)
        else $error("direction not all inputs after reset");
    chk_irq_reset: assert property ($past(RST_I) |-> !IRQ_O)
        else $error("interrupt high after reset");
    chk_irq_cause: assert property (
        $rose(IRQ_O) |-> $changed(PWM_OUT_O) || $past(wr_ph_ff))
        else $error("interrupt rose without cycle match");
    chk_irq_sticky: assert property (
        $fell(IRQ_O) && !$past(RST_I) |-> $past(wr_ph_ff))
        else $error("interrupt fell without a write");
    chk_dir_cause: assert property (
        $changed(P1_OE_N_O) && !$past(RST_I) |-> $past(wr_ph_ff))
        else $error("direction moved without a write");
    chk_pin_or: assert property (
        PWM_OUT_O |-> P1_PIN_O[6:5] == 2'b11)
        else $error("timer pins not driven by output");
    chk_pin_idle: assert property (
        !$past(wr_ph_ff) && !$past(RST_I) && $stable(PWM_OUT_O)
        |-> $stable(P1_PIN_O))
        else $error("pin drive moved without cause");
endmodule
bind tmpwm_top tmpwm_asserts u_chk (.SYS_CLK_I, .RST_I, .HSEL_I, .HTRANS_I,
    .HWRITE_I, .HREADY_I, .HREADYOUT_O, .HRESP_O, .P1_PIN_O, .P1_OE_N_O,
    .PWM_OUT_O, .IRQ_O);

// file: verification/tmpwm_pin_load.sv
// Model: external load on the port-1 pins
`timescale 1ns/1ps
module tmpwm_pin_load (
    input  wire logic       clk_i,   // Clock
    input  wire logic [7:0] drive_i, // Pin drive values
    input  wire logic [7:0] oe_n_i,  // Drive enable, low drives
    output logic      [7:0] pin_o    // Pin levels seen
);
    logic [7:0] last_ff;
    // Released pins float: show the inverse of the last driven level
    initial last_ff = 8'h00;
    initial pin_o = 8'h00;
    always @(posedge clk_i) begin
        last_ff <= (drive_i & ~oe_n_i) | (last_ff & oe_n_i);
        pin_o   <= (drive_i & ~oe_n_i) | (~last_ff & oe_n_i);
    end
endmodule

// file: verification/timer8_pwm_output_tb_top.sv
// Testbench: bus, port-1 and PWM waveform checks of the timer block
`timescale 1ns/1ps
module timer8_pwm_output_tb_top;
    logic        clk, rst, hsel, hwrite, hready, hresp, pwm, irq;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [7:0]  pin_in, pin_drv, oe_n;
    int          bad_count, n_tests;
    integer      seed;
    tmpwm_top uut (.SYS_CLK_I(clk), .RST_I(rst), .HSEL_I(hsel),
        .HADDR_I(haddr), .HTRANS_I(htrans), .HWRITE_I(hwrite),
        .HSIZE_I(hsize), .HREADY_I(hready), .HWDATA_I(hwdata),
        .HRDATA_O(hrdata), .HREADYOUT_O(hready), .HRESP_O(hresp),
        .P1_PIN_I(pin_in), .P1_PIN_O(pin_drv), .P1_OE_N_O(oe_n),
        .PWM_OUT_O(pwm), .IRQ_O(irq));
    tmpwm_pin_load u_load (.clk_i(clk), .drive_i(pin_drv), .oe_n_i(oe_n),
        .pin_o(pin_in));
    always #5 clk = ~clk;
    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            bad_count++;
            $display("wrong value %s: expected %h, seen %h", nm, e, g);
        end
    endtask
    task automatic tally_and_finish;
        $display("checks %0d, mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // Waits on ready at each edge; read data is taken at the second
    task automatic ahb(input logic w, input logic [11:0] a,
                       input logic [31:0] wd, output logic [31:0] rdv);
        hsel   <= 1'b1;
        htrans <= tmpwm_pkg::HTRANS_NSEQ;
        haddr  <= {20'h00000, a};
        hwrite <= w;
        do @(posedge clk); while (hready !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge clk); while (hready !== 1'b1);
        rdv = hrdata;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] x;
        ahb(1'b1, a, d, x);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] e,
                      input string nm);
        logic [31:0] x;
        ahb(1'b0, a, 32'h0000_0000, x);
        chk(nm, e, x);
        chk("hresp", 32'(tmpwm_pkg::HRESP_OKAY), 32'(hresp));
    endtask
    // Cycles spent high, then low, from the next rising output edge
    task automatic measure(output int hi, output int lo);
        int t;
        t = 0; hi = 0; lo = 0;
        while (pwm !== 1'b0 && t < 3000) begin
            @(posedge clk);
            #1;
            t++;
        end
        while (pwm !== 1'b1 && t < 3000) begin
            @(posedge clk);
            #1;
            t++;
        end
        while (pwm === 1'b1 && hi < 3000) begin
            @(posedge clk);
            #1;
            hi++;
        end
        while (pwm === 1'b0 && lo < 3000) begin
            @(posedge clk);
            #1;
            lo++;
        end
    endtask
    function automatic int span(input int n, input int ps);
        return n << ps;
    endfunction
    initial begin
        #500000;
        bad_count++;
        tally_and_finish();
    end
    initial begin
        logic [7:0] c, d, dir, lat;
        logic [31:0] pv, ctl;
        int hi, lo, ps;
        clk = 1'b0;
        rst = 1'b1;
        hsel = 1'b0;
        haddr = 32'h0000_0000;
        htrans = 2'h0;
        hwrite = 1'b0;
        hwdata = 32'h0000_0000;
        hsize = 3'h2;
        seed = 32'hD3CA8590;
        bad_count = 0;
        n_tests = 0;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rd(tmpwm_pkg::OFF_P1DIR, 32'h0000_00FF, "p1dir");
        rd(tmpwm_pkg::OFF_CYCLE, 32'h0000_00FF, "cycle");
        rd(tmpwm_pkg::OFF_P1LAT, 32'h0000_0000, "p1lat");
        rd(tmpwm_pkg::OFF_COUNT, 32'h0000_0000, "count");
        wr(12'h030, $random(seed));
        rd(12'h030, 32'h0000_0000, "unmapped");
        wr(tmpwm_pkg::OFF_P1DIR, 32'h0000_009F);
        wr(tmpwm_pkg::OFF_P1LAT, 32'h0000_0000);
        wr(tmpwm_pkg::OFF_MASK, 32'h0000_0001);
        for (int i = 0; i < 5; i++) begin
            c = (i == 0) ? 8'h01 : (8'($random(seed)) | 8'h02);
            d = (i == 0) ? 8'h00 : 8'({$random(seed)} % c);
            ps = i % 2;
            wr(tmpwm_pkg::OFF_CTRL, 32'h0000_0000);
            wr(tmpwm_pkg::OFF_CYCLE, {24'h000000, c});
            wr(tmpwm_pkg::OFF_DUTY, {24'h000000, d});
            ctl = 32'(ps << tmpwm_pkg::CTRL_DIVLSB) | 32'h0000_0003;
            wr(tmpwm_pkg::OFF_CTRL, ctl);
            measure(hi, lo);
            chk("high span", span(d + 1, ps), hi);
            chk("low span", span(c - d, ps), lo);
            chk("timer pins", 32'h0000_0003, 32'(pin_drv[6:5]));
        end
        d = d / 2;
        wr(tmpwm_pkg::OFF_DUTY, {24'h000000, d});
        measure(hi, lo);
        measure(hi, lo);
        chk("new duty", span(d + 1, 0), hi);
        wr(tmpwm_pkg::OFF_CTRL, 32'h0000_0002);
        repeat (40) @(posedge clk);
        #1;
        chk("stopped out", 32'(1'b0), 32'(pwm));
        rd(tmpwm_pkg::OFF_COUNT, 32'h0000_0000, "stopped count");
        chk("irq held", 32'(1'b1), 32'(irq));
        rd(tmpwm_pkg::OFF_STATUS, 32'h0000_0001, "status");
        wr(tmpwm_pkg::OFF_MASK, 32'h0000_0000);
        #1;
        chk("irq masked", 32'(1'b0), 32'(irq));
        wr(tmpwm_pkg::OFF_MASK, 32'h0000_0001);
        #1;
        chk("irq unmasked", 32'(1'b1), 32'(irq));
        wr(tmpwm_pkg::OFF_STATUS, 32'h0000_0001);
        #1;
        chk("irq cleared", 32'(1'b0), 32'(irq));
        for (int i = 0; i < 8; i++) begin
            dir = 8'($random(seed));
            lat = 8'($random(seed));
            wr(tmpwm_pkg::OFF_P1DIR, {24'h000000, dir});
            wr(tmpwm_pkg::OFF_P1LAT, {24'h000000, lat});
            wr(tmpwm_pkg::OFF_P1BIT, {28'h0000000, lat[i], 3'(i)});
            dir[i] = lat[i];
            rd(tmpwm_pkg::OFF_P1DIR, {24'h000000, dir}, "p1dir");
            chk("oe", {24'h000000, dir}, {24'h000000, oe_n});
            ahb(1'b0, tmpwm_pkg::OFF_P1BIT, 32'h0000_0000, pv);
            chk("pins", 32'(lat & ~dir), pv & 32'(~dir));
        end
        tally_and_finish();
    end
endmodule
